// ===== core/tc3_defines.vh
// Register map, field positions, reset values and divider counts of the timer block.
`ifndef TC3_DEFINES_VH
`define TC3_DEFINES_VH

// --------------------------------------------------------------
// Register word offsets (byte addresses)
// --------------------------------------------------------------
`define TC3_OFF_CONTROL   5'h00
`define TC3_OFF_RELOAD    5'h04
`define TC3_OFF_COUNT     5'h08
`define TC3_OFF_CAPTURE   5'h0C
`define TC3_OFF_STATUS    5'h10
`define TC3_OFF_MASK      5'h14
`define TC3_OFF_CONFIG    5'h18

// --------------------------------------------------------------
// Control register fields
// --------------------------------------------------------------
`define TC3_CTL_HI_FLAG   7
`define TC3_CTL_LO_FLAG   6
`define TC3_CTL_LO_IEN    5
`define TC3_CTL_CAP_EN    4
`define TC3_CTL_SPLIT     3
`define TC3_CTL_RUN       2
`define TC3_CTL_SEL_HI    1
`define TC3_CTL_SEL_LO    0

// --------------------------------------------------------------
// Status and mask fields, config fields
// --------------------------------------------------------------
`define TC3_ST_HI_OVF     0
`define TC3_ST_LO_OVF     1
`define TC3_ST_CAPTURE    2
`define TC3_CFG_TIMER_IEN 0
`define TC3_CFG_LO_EXT    1
`define TC3_CFG_HI_EXT    2

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define TC3_RST_CONTROL   8'h00
`define TC3_RST_RELOAD    16'h0000
`define TC3_RST_COUNT     16'h0000
`define TC3_RST_STATUS    3'h0
`define TC3_RST_MASK      3'h7
`define TC3_RST_CONFIG    3'h0

// --------------------------------------------------------------
// Clock source selections and dividers
// --------------------------------------------------------------
`define TC3_SEL_SYS_CMP   2'h0
`define TC3_SEL_OSC_CMP   2'h1
`define TC3_SEL_SYS_OSC   2'h2
`define TC3_SEL_CMP_OSC   2'h3
`define TC3_SYS_DIV       4'hC
`define TC3_OSC_DIV       3'h0

`endif

// ===== core/tc3_sync.v
// Three-stage synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module tc3_sync (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_n_i,
    // Asynchronous input and synchronised results
    input  wire async_i,
    output reg  level_o,
    output reg  rise_o
);

    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // --------------------------------------------------------------
    // Capture chain
    // --------------------------------------------------------------
    // The first stage feeds only the second, so metastability stays contained.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            rise_o <= 1'b0;
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
                rise_o  <= s3_reg & ~level_o;
            end
        end
    end

endmodule // tc3_sync

// ===== core/tc3_timer.v
// Timer control and status block with capture, split mode and Avalon-MM registers.
// What this block does
// [R1] In split mode the high flag is set when the upper byte overflows from FF and loads its reload byte.
// [R2] In 16-bit mode the high flag is set when the count overflows from FFFF and loads the reload value.
// [R3] With the timer interrupt enabled a set high flag requests an interrupt.
// [R4] Hardware never clears the high flag; software writes it to zero.
// [R5] The low flag is set when the lower byte overflows from FF and only software clears it.
// [R6] A low-byte overflow interrupts only when its own enable and the timer enable are both 1.
// [R7] With capture enabled each trigger copies the whole 16-bit count into the capture register.
// [R8] With capture, the timer interrupt and mask bit 2 enabled each capture requests an interrupt.
// [R9] With the split bit set the counter runs as two 8-bit timers, each with its own reload.
// [R10] With the split bit clear the counter runs as one 16-bit timer that reloads on overflow.
// [R11] The two flags, low interrupt enable, capture enable and split bit reset to 0 and are RW.
// [R12] In split mode the run bit gates only the upper byte; the lower byte always counts.
// [R13] The two-bit select field chooses the external count clock and the capture trigger.
// [R14] External clock sources are synchronised to the system clock before use.
// [R15] A hardware event in the same cycle as a software clear leaves the flag set.
`timescale 1ns/1ps
`include "tc3_defines.vh"
module tc3_timer (
    // Clock and reset
    input  wire        CLOCK_I,
    input  wire        RST_N_I,
    // Avalon-MM slave
    input  wire [4:0]  ADDRESS_I,
    input  wire        READ_I,
    input  wire        WRITE_I,
    input  wire [3:0]  BYTEENABLE_I,
    input  wire [31:0] WRITEDATA_I,
    output reg  [31:0] READDATA_O,
    output reg         WAITREQUEST_O,
    // External clock and trigger pins
    input  wire        EXT_OSC_I,
    input  wire        COMPARATOR_I,
    // Interrupt
    output reg         IRQ_O
);

    reg  [7:0]  control_reg;
    reg  [7:0]  control_next;
    reg  [15:0] reload_reg;
    reg  [15:0] reload_next;
    reg  [15:0] count_reg;
    reg  [15:0] count_next;
    reg  [15:0] capture_reg;
    reg  [15:0] capture_next;
    reg  [2:0]  status_reg;
    reg  [2:0]  status_next;
    reg  [2:0]  mask_reg;
    reg  [2:0]  mask_next;
    reg  [2:0]  config_reg;
    reg  [2:0]  config_next;
    reg  [3:0]  sys_div_reg;
    reg  [3:0]  sys_div_next;
    reg  [2:0]  osc_div_reg;
    reg  [2:0]  osc_div_next;
    reg  [31:0] rdata_next;
    reg         irq_next;
    reg         ext_tick;
    reg         cap_tick;
    reg         lo_tick;
    reg         hi_tick;
    reg         hi_ovf;
    reg         lo_ovf;
    reg         cap_evt;
    reg         irq_hi_term;
    reg         irq_lo_term;
    reg         irq_cap_term;
    reg         irq_st_term;

    wire        osc_rise;
    wire        cmp_rise;
    wire        sys_tick;
    wire        osc_tick;
    wire        acc;
    wire        acc_wr;
    wire        acc_rd;
    wire [1:0]  sel;
    wire        wr_control;
    wire        wr_reload;
    wire        wr_count;
    wire        wr_mask;
    wire        wr_config;
    wire        rd_status;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    tc3_sync u_osc_sync (  // see [R14]
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .async_i (EXT_OSC_I),
        .level_o (),
        .rise_o  (osc_rise)
    );

    tc3_sync u_cmp_sync (  // see [R14]
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .async_i (COMPARATOR_I),
        .level_o (),
        .rise_o  (cmp_rise)
    );

    // --------------------------------------------------------------
    // Bus handshake
    // --------------------------------------------------------------
    // One wait cycle per access keeps read data registered and the decode off the path.
    assign acc    = (READ_I | WRITE_I) & ~WAITREQUEST_O;
    assign acc_wr = WRITE_I & ~WAITREQUEST_O;
    assign acc_rd = READ_I & ~WAITREQUEST_O;
    assign sel    = control_reg[`TC3_CTL_SEL_HI:`TC3_CTL_SEL_LO];

    // --------------------------------------------------------------
    // Register decode
    // --------------------------------------------------------------
    // Each strobe is live only on the edge that completes the access, never in the wait cycle.
    assign wr_control = acc_wr & (ADDRESS_I == `TC3_OFF_CONTROL);
    assign wr_reload  = acc_wr & (ADDRESS_I == `TC3_OFF_RELOAD);
    assign wr_count   = acc_wr & (ADDRESS_I == `TC3_OFF_COUNT);
    assign wr_mask    = acc_wr & (ADDRESS_I == `TC3_OFF_MASK);
    assign wr_config  = acc_wr & (ADDRESS_I == `TC3_OFF_CONFIG);
    assign rd_status  = acc_rd & (ADDRESS_I == `TC3_OFF_STATUS);

    // --------------------------------------------------------------
    // Clock sources
    // --------------------------------------------------------------
    assign sys_tick = (sys_div_reg == (`TC3_SYS_DIV - 4'h1));
    assign osc_tick = osc_rise & (osc_div_reg == (`TC3_OSC_DIV - 3'h1));

    always @* begin
        sys_div_next = sys_tick ? 4'h0 : sys_div_reg + 4'h1;
        osc_div_next = osc_rise ? osc_div_reg + 3'h1 : osc_div_reg;
        case (sel)  // see [R13]
            `TC3_SEL_SYS_CMP: begin
                ext_tick = sys_tick;
                cap_tick = cmp_rise;
            end
            `TC3_SEL_OSC_CMP: begin
                ext_tick = osc_tick;
                cap_tick = cmp_rise;
            end
            `TC3_SEL_SYS_OSC: begin
                ext_tick = sys_tick;
                cap_tick = osc_tick;
            end
            `TC3_SEL_CMP_OSC: begin
                ext_tick = cmp_rise;
                cap_tick = osc_tick;
            end
            default: begin
                ext_tick = 1'b0;
                cap_tick = 1'b0;
            end
        endcase
        lo_tick = config_reg[`TC3_CFG_LO_EXT] ? ext_tick : 1'b1;
        hi_tick = config_reg[`TC3_CFG_HI_EXT] ? ext_tick : 1'b1;
    end

    // --------------------------------------------------------------
    // Counter
    // --------------------------------------------------------------
    always @* begin
        count_next = count_reg;
        hi_ovf     = 1'b0;
        lo_ovf     = 1'b0;
        if (control_reg[`TC3_CTL_SPLIT]) begin  // see [R9]
            if (lo_tick) begin  // see [R12]
                if (count_reg[7:0] == 8'hFF) begin
                    count_next[7:0] = reload_reg[7:0];
                    lo_ovf          = 1'b1;  // see [R5]
                end else begin
                    count_next[7:0] = count_reg[7:0] + 8'h01;
                end
            end
            if (control_reg[`TC3_CTL_RUN] && hi_tick) begin  // see [R12]
                if (count_reg[15:8] == 8'hFF) begin
                    count_next[15:8] = reload_reg[15:8];
                    hi_ovf           = 1'b1;  // see [R1]
                end else begin
                    count_next[15:8] = count_reg[15:8] + 8'h01;
                end
            end
        end else if (control_reg[`TC3_CTL_RUN] && lo_tick) begin  // see [R10]
            if (count_reg == 16'hFFFF) begin
                count_next = reload_reg;
                hi_ovf     = 1'b1;  // see [R2]
            end else begin
                count_next = count_reg + 16'h0001;
            end
            lo_ovf = (count_reg[7:0] == 8'hFF);  // see [R5]
        end
        // A count write wins over a same-cycle tick; the flags that tick raised still stand.
        if (wr_count) begin
            if (BYTEENABLE_I[0]) begin
                count_next[7:0] = WRITEDATA_I[7:0];
            end
            if (BYTEENABLE_I[1]) begin
                count_next[15:8] = WRITEDATA_I[15:8];
            end
        end
    end

    // --------------------------------------------------------------
    // Capture
    // --------------------------------------------------------------
    always @* begin
        cap_evt      = control_reg[`TC3_CTL_CAP_EN] & cap_tick;
        capture_next = cap_evt ? count_reg : capture_reg;  // see [R7]
    end

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    always @* begin
        control_next = control_reg;
        reload_next  = reload_reg;
        mask_next    = mask_reg;
        config_next  = config_reg;
        status_next  = status_reg;
        if (wr_control && BYTEENABLE_I[0]) begin
            control_next = WRITEDATA_I[7:0];  // see [R11] [R4]
        end
        if (wr_reload && BYTEENABLE_I[0]) begin
            reload_next[7:0] = WRITEDATA_I[7:0];
        end
        if (wr_reload && BYTEENABLE_I[1]) begin
            reload_next[15:8] = WRITEDATA_I[15:8];
        end
        if (wr_mask && BYTEENABLE_I[0]) begin
            mask_next = WRITEDATA_I[2:0];
        end
        if (wr_config && BYTEENABLE_I[0]) begin
            config_next = WRITEDATA_I[2:0];
        end
        if (rd_status) begin
            status_next = 3'h0;
        end
        // Hardware sets are applied last so they win over a same-cycle clear.
        if (hi_ovf) begin
            control_next[`TC3_CTL_HI_FLAG] = 1'b1;  // see [R15]
            status_next[`TC3_ST_HI_OVF]    = 1'b1;
        end
        if (lo_ovf) begin
            control_next[`TC3_CTL_LO_FLAG] = 1'b1;  // see [R15]
            status_next[`TC3_ST_LO_OVF]    = 1'b1;
        end
        if (cap_evt) begin
            status_next[`TC3_ST_CAPTURE] = 1'b1;  // see [R15]
        end
    end

    // --------------------------------------------------------------
    // Read data multiplexer
    // --------------------------------------------------------------
    always @* begin
        case (ADDRESS_I)
            `TC3_OFF_CONTROL: rdata_next = {24'h000000, control_reg};
            `TC3_OFF_RELOAD:  rdata_next = {16'h0000, reload_reg};
            `TC3_OFF_COUNT:   rdata_next = {16'h0000, count_reg};
            `TC3_OFF_CAPTURE: rdata_next = {16'h0000, capture_reg};
            `TC3_OFF_STATUS:  rdata_next = {29'h00000000, status_reg};
            `TC3_OFF_MASK:    rdata_next = {29'h00000000, mask_reg};
            `TC3_OFF_CONFIG:  rdata_next = {29'h00000000, config_reg};
            default:          rdata_next = 32'h00000000;
        endcase
    end

    // --------------------------------------------------------------
    // Interrupt terms
    // --------------------------------------------------------------
    // The flag terms follow software clears and the status term follows the read clear.
    always @* begin
        irq_hi_term  = control_next[`TC3_CTL_HI_FLAG];  // see [R3]
        irq_lo_term  = control_next[`TC3_CTL_LO_IEN] & control_next[`TC3_CTL_LO_FLAG];  // see [R6]
        irq_cap_term = status_next[`TC3_ST_CAPTURE] & mask_next[`TC3_ST_CAPTURE];  // see [R8]
        irq_st_term  = |(status_next & mask_next & {1'b0, control_next[`TC3_CTL_LO_IEN], 1'b1});
        irq_next     = config_reg[`TC3_CFG_TIMER_IEN]
                     & (irq_hi_term | irq_lo_term | irq_cap_term | irq_st_term);
    end

    // --------------------------------------------------------------
    // Bus outputs
    // --------------------------------------------------------------
    // Read data are loaded in the wait cycle and then hold, so a late sample still sees them.
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            READDATA_O    <= 32'h00000000;
            WAITREQUEST_O <= 1'b1;
        end else begin
            READDATA_O    <= (READ_I & WAITREQUEST_O) ? rdata_next : READDATA_O;
            WAITREQUEST_O <= ~((READ_I | WRITE_I) & WAITREQUEST_O & ~acc);
        end
    end

    // --------------------------------------------------------------
    // Counter, capture and dividers
    // --------------------------------------------------------------
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            count_reg     <= `TC3_RST_COUNT;
            capture_reg   <= `TC3_RST_COUNT;
            sys_div_reg   <= 4'h0;
            osc_div_reg   <= 3'h0;
        end else begin
            count_reg     <= count_next;
            capture_reg   <= capture_next;
            sys_div_reg   <= sys_div_next;
            osc_div_reg   <= osc_div_next;
        end
    end

    // --------------------------------------------------------------
    // Software registers and flags
    // --------------------------------------------------------------
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            control_reg   <= `TC3_RST_CONTROL;  // see [R11]
            reload_reg    <= `TC3_RST_RELOAD;
            status_reg    <= `TC3_RST_STATUS;
            mask_reg      <= `TC3_RST_MASK;
            config_reg    <= `TC3_RST_CONFIG;
        end else begin
            control_reg   <= control_next;
            reload_reg    <= reload_next;
            status_reg    <= status_next;
            mask_reg      <= mask_next;
            config_reg    <= config_next;
        end
    end

    // --------------------------------------------------------------
    // Interrupt output
    // --------------------------------------------------------------
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_O         <= 1'b0;
        end else begin
            IRQ_O         <= irq_next;
        end
    end

endmodule // tc3_timer

// ===== dv/tc3_timer_chk.sv
// Port assertions of the timer control block.
`timescale 1ns/1ps
`include "tc3_defines.vh"
module tc3_timer_chk (
    // Clock and reset
    input wire        CLOCK_I,
    input wire        RST_N_I,
    // Register bus
    input wire [4:0]  ADDRESS_I,
    input wire        READ_I,
    input wire        WRITE_I,
    input wire [3:0]  BYTEENABLE_I,
    input wire [31:0] WRITEDATA_I,
    input wire [31:0] READDATA_O,
    input wire        WAITREQUEST_O,
    // Pins and interrupt
    input wire        EXT_OSC_I,
    input wire        COMPARATOR_I,
    input wire        IRQ_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    wire rd_acc  = READ_I && !WAITREQUEST_O;
    wire any_acc = (READ_I || WRITE_I) && !WAITREQUEST_O;
    wire ien_off = any_acc && WRITE_I && ADDRESS_I == `TC3_OFF_CONFIG && BYTEENABLE_I[0]
                   && !WRITEDATA_I[0];
    sequence s_req; (READ_I || WRITE_I) && WAITREQUEST_O; endsequence
    sequence s_one_wait; !WAITREQUEST_O ##1 WAITREQUEST_O; endsequence
    property p_answer; s_req |=> s_one_wait; endproperty
    property p_idle; !(READ_I || WRITE_I) |=> WAITREQUEST_O; endproperty
    // Read data must hold between reads, as software may sample them late.
    property p_rd_hold; !READ_I |=> $stable(READDATA_O); endproperty
    property p_unmapped; rd_acc && ADDRESS_I == 5'h1C |-> READDATA_O == 32'h0; endproperty
    property p_ctl_width;
        rd_acc && ADDRESS_I == `TC3_OFF_CONTROL |-> READDATA_O[31:8] == 24'h0;
    endproperty
    property p_narrow;
        rd_acc && ADDRESS_I >= `TC3_OFF_STATUS |-> READDATA_O[31:3] == 29'h0;
    endproperty
    property p_irq_off; ien_off |=> ##1 !IRQ_O; endproperty
    property p_irq_fall; $fell(IRQ_O) |-> $past(any_acc) || $past(any_acc, 2); endproperty
    a_answer: assert property (p_answer) else $error("bus wait is not one cycle");
    a_idle: assert property (p_idle) else $error("waitrequest low with no request");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ctl_width: assert property (p_ctl_width) else $error("control upper bits set");
    a_narrow: assert property (p_narrow) else $error("narrow register upper bits set");
    a_irq_off: assert property (p_irq_off) else $error("interrupt high while disabled");
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without access");
endmodule // tc3_timer_chk

// ===== dv/test_timer3_control_flags.sv
// Self-checking bench of the timer control block driven over its register bus.
`timescale 1ns/1ps
`include "tc3_defines.vh"
module test_timer3_control_flags;
    localparam [4:0] ctl_a = `TC3_OFF_CONTROL;
    localparam [4:0] cnt_a = `TC3_OFF_COUNT;
    reg         clk             = 1'b0;
    reg         rst_n           = 1'b0;
    reg  [4:0]  address         = 5'h00;
    reg         read            = 1'b0;
    reg         write           = 1'b0;
    reg  [31:0] writedata       = 32'h0;
    reg         ext_osc         = 1'b0;
    reg         comparator      = 1'b0;
    wire [31:0] readdata;
    wire        waitrequest;
    wire        irq;
    reg  [31:0] rd;
    integer     bad_count       = 0;
    integer     samples_checked = 0;
    integer     i;
    always #10 clk = ~clk;
    tc3_timer u_dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .ADDRESS_I(address), .READ_I(read),
        .WRITE_I(write), .BYTEENABLE_I(4'hF), .WRITEDATA_I(writedata), .READDATA_O(readdata),
        .WAITREQUEST_O(waitrequest), .EXT_OSC_I(ext_osc), .COMPARATOR_I(comparator),
        .IRQ_O(irq)
    );
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task check(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // The wait covers a low byte reload period, so a fresh overflow has landed.
    task irq_is(input exp);
        idle(12);
        check({31'h0, irq}, {31'h0, exp});
    endtask
    // The request holds until the edge that samples waitrequest low; one idle edge follows.
    task bus(input wr, input [4:0] a, input [31:0] d);
        integer n;
        n = 0;
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 40) begin
            @(posedge clk);
            n = n + 1;
        end
        if (n >= 40) bad_count = bad_count + 1;
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clk);
    endtask
    task rdc(input [4:0] a, input [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(ctl_a, 32'h0);
        rdc(`TC3_OFF_MASK, {29'h0, `TC3_RST_MASK});
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        rdc(5'h1C, 32'h0);
        bus(1'b1, ctl_a, 32'h3B);
        rdc(ctl_a, 32'h3B);
        bus(1'b1, ctl_a, 32'h0);
        $display("test registers done");
        bus(1'b1, `TC3_OFF_CONFIG, 32'h1);
        bus(1'b1, `TC3_OFF_RELOAD, 32'h1234);
        bus(1'b1, cnt_a, 32'hFFF0);
        bus(1'b1, ctl_a, 32'h04);
        idle(30);
        rdc(ctl_a, 32'hC4);
        irq_is(1'b1);
        bus(1'b0, cnt_a, 32'h0);
        check({24'h0, rd[15:8]}, 32'h12);
        idle(200);
        rdc(ctl_a, 32'hC4);
        bus(1'b1, ctl_a, 32'h0);
        rdc(ctl_a, 32'h0);
        rdc(`TC3_OFF_STATUS, 32'h3);
        irq_is(1'b0);
        $display("test sixteen_bit done");
        bus(1'b1, `TC3_OFF_RELOAD, 32'hF0F8);
        bus(1'b1, cnt_a, 32'hFC);
        bus(1'b1, ctl_a, 32'h08);
        idle(20);
        rdc(ctl_a, 32'h48);
        bus(1'b0, cnt_a, 32'h0);
        check({24'h0, rd[15:8]}, 32'h0);
        check({31'h0, rd[7:0] >= 8'hF8}, 32'h1);
        irq_is(1'b0);
        bus(1'b1, ctl_a, 32'h28);
        irq_is(1'b1);
        bus(1'b1, ctl_a, 32'h0C);
        idle(270);
        rdc(ctl_a, 32'hCC);
        bus(1'b0, cnt_a, 32'h0);
        check({28'h0, rd[15:12]}, 32'hF);
        bus(1'b1, ctl_a, 32'h0);
        rdc(`TC3_OFF_STATUS, 32'h3);
        $display("test split done");
        // Select 0 takes the comparator as trigger, select 2 the divided oscillator.
        for (i = 0; i < 2; i = i + 1) begin
            bus(1'b1, ctl_a, {24'h0, 6'h04, i[0], 1'b0});
            bus(1'b1, cnt_a, {16'h0, 16'hA5C3 ^ {16{i[0]}}});
            rdc(`TC3_OFF_STATUS, 32'h0);
            repeat (24) begin
                comparator <= (i == 0);
                ext_osc    <= (i == 1);
                idle(3);
                comparator <= 1'b0;
                ext_osc    <= 1'b0;
                idle(3);
            end
            irq_is(1'b1);
            rdc(`TC3_OFF_CAPTURE, {16'h0, 16'hA5C3 ^ {16{i[0]}}});
            rdc(`TC3_OFF_STATUS, 32'h4);
            irq_is(1'b0);
        end
        $display("test capture done");
        // A flag set by software raises the interrupt until the timer enable is dropped.
        bus(1'b1, ctl_a, 32'h80);
        irq_is(1'b1);
        bus(1'b1, `TC3_OFF_CONFIG, 32'h0);
        irq_is(1'b0);
        bus(1'b1, ctl_a, 32'h0);
        $display("test enable done");
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count = bad_count + 1;
        final_report;
    end
endmodule // test_timer3_control_flags
bind tc3_timer tc3_timer_chk u_chk (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I),
    .WRITE_I(WRITE_I), .BYTEENABLE_I(BYTEENABLE_I), .WRITEDATA_I(WRITEDATA_I),
    .READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O), .EXT_OSC_I(EXT_OSC_I),
    .COMPARATOR_I(COMPARATOR_I), .IRQ_O(IRQ_O)
);
